/* File: rtl/sif_defs.vh */
// Purpose: Constants for the stage interrupt flag block.
// Assumes: Sixteen-bit registers addressed by a ten-bit register index.
// Notes: Offsets are register indices on the device's own register port.
`ifndef SIF_DEFS_VH
`define SIF_DEFS_VH
`define SIF_ADDR_W 10
`define SIF_DATA_W 16
`define SIF_OFS_DONE_EN 10'h007
`define SIF_OFS_LOW_FLAGS 10'h008
`define SIF_OFS_HIGH_FLAGS 10'h009
`define SIF_OFS_HIGH_EN 10'h006
`define SIF_OFS_DONE_STATUS 10'h00A
`define SIF_GPIO_EN_BIT 12
`define SIF_RESET_WORD 16'h0000
`endif

/* File: rtl/sif_stage_interrupt_flags.v */
// Purpose: Interrupt enables, limit flags and the active-low interrupt output of a twelve-stage sensing controller.
// Assumes: One clock; register port is a simple strobed read/write port; all inputs synchronous to the clock.
// Notes: Flags clear after a read only where their condition has gone away.
`include "sif_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module sif_stage_interrupt_flags #(
  parameter STAGES = 12
) (
  input wire clock,
  input wire reset,
  input wire reg_write,
  input wire reg_read,
  input wire [`SIF_ADDR_W-1:0] reg_addr,
  input wire [`SIF_DATA_W-1:0] reg_wdata,
  output reg [`SIF_DATA_W-1:0] reg_rdata,
  input wire [STAGES-1:0] stage_done,
  input wire [STAGES-1:0] low_exceeded,
  input wire [STAGES-1:0] high_exceeded,
  input wire gpio_in,
  output wire int_n
);
  // Enable registers and their next values.
  reg [STAGES-1:0] done_irq_en;
  reg gpio_irq_en;
  reg [STAGES-1:0] high_irq_en;
  reg [STAGES-1:0] next_done_irq_en;
  reg next_gpio_irq_en;
  reg [STAGES-1:0] next_high_irq_en;

  // Sticky event flags, one per stage and one for the GPIO pin.
  reg [STAGES-1:0] low_flag;
  reg [STAGES-1:0] high_flag;
  reg [STAGES-1:0] done_flag;
  reg gpio_flag;
  wire [STAGES-1:0] next_low_flag;
  wire [STAGES-1:0] next_high_flag;
  wire [STAGES-1:0] next_done_flag;
  reg next_gpio_flag;

  // Per-stage interrupt sources after masking.
  wire [STAGES-1:0] done_source;
  wire [STAGES-1:0] high_source;

  // GPIO change detection.
  reg gpio_last;
  reg gpio_primed;
  wire gpio_change;

  // Interrupt state.
  reg int_active;
  reg next_int_active;

  // Register port decode.
  wire sel_done_en;
  wire sel_high_en;
  wire sel_low_flags;
  wire sel_high_flags;
  wire sel_done_status;
  wire wr_done_en;
  wire wr_high_en;
  wire rd_low;
  wire rd_high;
  wire rd_done;

  // Read words, assembled with the unused upper bits at zero.
  reg [`SIF_DATA_W-1:0] done_en_word;
  reg [`SIF_DATA_W-1:0] high_en_word;
  reg [`SIF_DATA_W-1:0] low_flag_word;
  reg [`SIF_DATA_W-1:0] high_flag_word;
  reg [`SIF_DATA_W-1:0] done_status_word;
  reg [`SIF_DATA_W-1:0] next_rdata;

  genvar stage;

  assign sel_done_en = (reg_addr == `SIF_OFS_DONE_EN);
  assign sel_high_en = (reg_addr == `SIF_OFS_HIGH_EN);
  assign sel_low_flags = (reg_addr == `SIF_OFS_LOW_FLAGS);
  assign sel_high_flags = (reg_addr == `SIF_OFS_HIGH_FLAGS);
  assign sel_done_status = (reg_addr == `SIF_OFS_DONE_STATUS);

  assign wr_done_en = reg_write && sel_done_en;
  assign wr_high_en = reg_write && sel_high_en;
  assign rd_low = reg_read && sel_low_flags;
  assign rd_high = reg_read && sel_high_flags;
  assign rd_done = reg_read && sel_done_status;

  // The interrupt sees a new enable in the cycle of its write, so a cleared enable releases at once.
  always @* begin
    next_done_irq_en = done_irq_en;
    next_gpio_irq_en = gpio_irq_en;
    next_high_irq_en = high_irq_en;
    if (wr_done_en) begin
      next_done_irq_en = reg_wdata[STAGES-1:0];
      next_gpio_irq_en = reg_wdata[`SIF_GPIO_EN_BIT];
    end
    if (wr_high_en) begin
      next_high_irq_en = reg_wdata[STAGES-1:0];
    end
  end

  // A new event in the read cycle wins over the clear, so a limit still exceeded keeps its flag.
  generate
    for (stage = 0; stage < STAGES; stage = stage + 1) begin : g_stage
      assign next_low_flag[stage] = (rd_low ? 1'b0 : low_flag[stage]) | low_exceeded[stage];
      assign next_high_flag[stage] = (rd_high ? 1'b0 : high_flag[stage]) | high_exceeded[stage];
      assign next_done_flag[stage] = (rd_done ? 1'b0 : done_flag[stage]) | stage_done[stage];
      assign done_source[stage] = next_done_flag[stage] & next_done_irq_en[stage];
      assign high_source[stage] = next_high_flag[stage] & next_high_irq_en[stage];
    end
  endgenerate

  // The first cycle after reset only learns the pin level, so no false change follows reset.
  assign gpio_change = gpio_primed && (gpio_in != gpio_last);

  always @* begin
    next_gpio_flag = gpio_flag;
    if (rd_done) begin
      next_gpio_flag = 1'b0;
    end
    if (gpio_change) begin
      next_gpio_flag = 1'b1;
    end
  end

  // The interrupt follows the next flag state, so it moves on the edge that takes the event.
  always @* begin
    next_int_active = 1'b0;
    if (|done_source) begin
      next_int_active = 1'b1;
    end
    if (next_gpio_flag && next_gpio_irq_en) begin
      next_int_active = 1'b1;
    end
    if (|high_source) begin
      next_int_active = 1'b1;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      done_irq_en <= {STAGES{1'b0}};
      gpio_irq_en <= 1'b0;
      high_irq_en <= {STAGES{1'b0}};
    end else begin
      done_irq_en <= next_done_irq_en;
      gpio_irq_en <= next_gpio_irq_en;
      high_irq_en <= next_high_irq_en;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      low_flag <= {STAGES{1'b0}};
      high_flag <= {STAGES{1'b0}};
      done_flag <= {STAGES{1'b0}};
      gpio_flag <= 1'b0;
    end else begin
      low_flag <= next_low_flag;
      high_flag <= next_high_flag;
      done_flag <= next_done_flag;
      gpio_flag <= next_gpio_flag;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      gpio_last <= 1'b0;
      gpio_primed <= 1'b0;
    end else begin
      gpio_last <= gpio_in;
      gpio_primed <= 1'b1;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      int_active <= 1'b0;
    end else begin
      int_active <= next_int_active;
    end
  end

  always @* begin
    done_en_word = `SIF_RESET_WORD;
    done_en_word[STAGES-1:0] = done_irq_en;
    done_en_word[`SIF_GPIO_EN_BIT] = gpio_irq_en;
    high_en_word = `SIF_RESET_WORD;
    high_en_word[STAGES-1:0] = high_irq_en;
    low_flag_word = `SIF_RESET_WORD;
    low_flag_word[STAGES-1:0] = low_flag;
    high_flag_word = `SIF_RESET_WORD;
    high_flag_word[STAGES-1:0] = high_flag;
    done_status_word = `SIF_RESET_WORD;
    done_status_word[STAGES-1:0] = done_flag;
    done_status_word[`SIF_GPIO_EN_BIT] = gpio_flag;
  end

  // Unmapped indices read as zero.
  always @* begin
    case (reg_addr)
      `SIF_OFS_DONE_EN: begin
        next_rdata = done_en_word;
      end
      `SIF_OFS_HIGH_EN: begin
        next_rdata = high_en_word;
      end
      `SIF_OFS_LOW_FLAGS: begin
        next_rdata = low_flag_word;
      end
      `SIF_OFS_HIGH_FLAGS: begin
        next_rdata = high_flag_word;
      end
      `SIF_OFS_DONE_STATUS: begin
        next_rdata = done_status_word;
      end
      default: begin
        next_rdata = `SIF_RESET_WORD;
      end
    endcase
  end

  // Read data shows the flags as they stood before the read clears them, and holds until the next read.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= `SIF_RESET_WORD;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  assign int_n = ~int_active;
endmodule
`default_nettype wire

/* File: testbench/sif_monitor.sv */
// Purpose: Port checks for the stage flag block.
// Assumes: One clock, reset active high.
// Notes: Bound to the block top below.
`timescale 1ns/100ps
`default_nettype none
module sif_monitor(
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic int_n,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [11:0] low_exceeded
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  wire w7 = reg_write && (reg_addr == 10'h007);
  wire r7 = reg_read && (reg_addr == 10'h007);
  wire r8 = reg_read && (reg_addr == 10'h008);
  wire r9 = reg_read && (reg_addr == 10'h009);
  en_back_a: assert property (w7 ##2 r7 |=> reg_rdata == ($past(reg_wdata, 3) & 16'h1FFF))
    else $error("enable readback differs from write");
  en_pad_a: assert property (r7 |=> reg_rdata[15:13] == 3'h0)
    else $error("enable upper bits not zero");
  low_pad_a: assert property (r8 |=> reg_rdata[15:12] == 4'h0)
    else $error("low flag upper bits not zero");
  high_pad_a: assert property (r9 |=> reg_rdata[15:12] == 4'h0)
    else $error("high flag upper bits not zero");
  low_flag_a: assert property (r8 ##2 r8 |=> reg_rdata == ($past(low_exceeded, 2) | $past(low_exceeded, 3)))
    else $error("low flag not cleared by read");
  int_rise_a: assert property ($rose(int_n) |-> $past(reg_read || reg_write))
    else $error("interrupt released without host access");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without read");
  unmapped_read_a: assert property (reg_read && reg_addr > 10'h00A |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind sif_stage_interrupt_flags sif_monitor u_sif_monitor(
  .clock(clock),
  .reset(reset),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .int_n(int_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .low_exceeded(low_exceeded)
);
`default_nettype wire

/* File: testbench/sif_host.sv */
// Purpose: Host model on the register port.
// Assumes: One access at a time.
// Notes: Each access waits one idle edge, then its strobe spans one rising edge.
`timescale 1ns/100ps
`default_nettype none
module sif_host(
  input wire logic clock,
  input wire logic [15:0] reg_rdata,
  output logic reg_write,
  output logic reg_read,
  output logic [9:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
  end

  // The strobe stands over exactly one rising edge; read data is valid from that edge on.
  task acc(input logic w, input logic [9:0] a, input logic [15:0] v, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_write = w;
    reg_read = !w;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: testbench/sif_stage_interrupt_flags_tb.sv */
// Purpose: Self-checking bench for the stage flag block.
// Assumes: Inputs move 1 ns after the rising edge.
// Notes: The host model makes every register access.
`timescale 1ns/100ps
`default_nettype none
module sif_stage_interrupt_flags_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic gpio_in = 1'b0;
  logic reg_write;
  logic reg_read;
  logic [11:0] stage_done = 12'h000;
  logic [11:0] low_exceeded = 12'h000;
  logic [11:0] high_exceeded = 12'h000;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] d;
  logic [9:0] reg_addr;
  wire int_n;
  int fails = 0;
  int comparisons = 0;

  always #50 clock = ~clock;

  sif_host u_sif_host(
    .clock(clock),
    .reg_rdata(reg_rdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata)
  );

  sif_stage_interrupt_flags u_sif_stage_interrupt_flags(
    .clock(clock),
    .reset(reset),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .stage_done(stage_done),
    .low_exceeded(low_exceeded),
    .high_exceeded(high_exceeded),
    .gpio_in(gpio_in),
    .int_n(int_n)
  );

  task ck(input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected) begin
      fails++;
      $display("BAD %0t mismatch seen %h expected %h", $time, seen, expected);
    end
  endtask

  task tk;
    @(posedge clock);
    #1;
  endtask

  task rw(input logic w, input logic [9:0] a, input logic [15:0] v);
    u_sif_host.acc(w, a, v, d);
  endtask

  task t_regs;
    ck(int_n, 16'h0001);
    rw(1'b0, 10'h007, 16'h0000);
    ck(d, 16'h0000);
    rw(1'b1, 10'h007, 16'hFFFF);
    rw(1'b0, 10'h007, 16'h0000);
    ck(d, 16'h1FFF);
    rw(1'b0, 10'h008, 16'h0000);
    ck(d, 16'h0000);
    rw(1'b0, 10'h009, 16'h0000);
    ck(d, 16'h0000);
    rw(1'b0, 10'h00C, 16'h0000);
    ck(d, 16'h0000);
    $display("t_regs done");
  endtask

  task t_done;
    stage_done = 12'h800;
    tk;
    stage_done = 12'h000;
    tk;
    ck(int_n, 16'h0000);
    rw(1'b0, 10'h00A, 16'h0000);
    ck(d, 16'h0800);
    tk;
    ck(int_n, 16'h0001);
    gpio_in = 1'b1;
    tk;
    tk;
    ck(int_n, 16'h0000);
    rw(1'b1, 10'h007, 16'h0000);
    ck(int_n, 16'h0001);
    $display("t_done done");
  endtask

  task t_lim;
    stage_done = 12'hFFF;
    gpio_in = 1'b0;
    rw(1'b1, 10'h006, 16'h0004);
    stage_done = 12'h000;
    ck(int_n, 16'h0001);
    low_exceeded = 12'h801;
    high_exceeded = 12'h004;
    tk;
    ck(int_n, 16'h0000);
    low_exceeded = 12'h000;
    tk;
    ck(int_n, 16'h0000);
    rw(1'b0, 10'h008, 16'h0000);
    ck(d, 16'h0801);
    rw(1'b0, 10'h008, 16'h0000);
    ck(d, 16'h0000);
    rw(1'b0, 10'h009, 16'h0000);
    ck(d, 16'h0004);
    ck(int_n, 16'h0000);
    high_exceeded = 12'h000;
    rw(1'b0, 10'h009, 16'h0000);
    ck(d, 16'h0004);
    ck(int_n, 16'h0001);
    rw(1'b0, 10'h009, 16'h0000);
    ck(d, 16'h0000);
    tk;
    ck(int_n, 16'h0001);
    $display("t_lim done");
  endtask

  task final_report;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    t_regs;
    t_done;
    t_lim;
    final_report;
  end

  // The tests need about forty cycles; the watchdog allows 500, over twelve times that.
  initial begin
    #50000;
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
